// *** rtl/ccb_pkg.sv ***
// ccb_pkg: shared constants and types for the capture/compare/bridge pwm unit
// assumes one 20 MHz system clock; timers live outside the unit
package ccb_pkg;

    localparam int          CLK_HZ         = 20_000_000;
    localparam int          QCLK_DIV       = 4;        // instruction cycle = four clock periods
    localparam logic [1:0]  QCLK_LAST      = 2'h3;

    // mode select encodings
    localparam logic [3:0]  MODE_OFF       = 4'h0;
    localparam logic [3:0]  MODE_CMP_TOG   = 4'h2;
    localparam logic [3:0]  MODE_CAP_FALL  = 4'h4;
    localparam logic [3:0]  MODE_CAP_RISE  = 4'h5;
    localparam logic [3:0]  MODE_CAP_R4    = 4'h6;
    localparam logic [3:0]  MODE_CAP_R16   = 4'h7;
    localparam logic [3:0]  MODE_CMP_SET   = 4'h8;
    localparam logic [3:0]  MODE_CMP_CLR   = 4'h9;
    localparam logic [3:0]  MODE_CMP_SWI   = 4'ha;
    localparam logic [3:0]  MODE_CMP_SPEV  = 4'hb;

    // bridge mode encodings
    localparam logic [1:0]  BRIDGE_SINGLE  = 2'h0;
    localparam logic [1:0]  BRIDGE_FWD     = 2'h1;
    localparam logic [1:0]  BRIDGE_HALF    = 2'h2;
    localparam logic [1:0]  BRIDGE_REV     = 2'h3;

    // prescale terminal counts (count of edges minus one)
    localparam logic [3:0]  PRESC_LAST_4   = 4'h3;
    localparam logic [3:0]  PRESC_LAST_16  = 4'hf;

    localparam logic [7:0]  CTRL_RESET     = 8'h00;
    localparam logic [6:0]  DEADBAND_RESET = 7'h00;

    // unit control register image
    typedef struct packed {
        logic [1:0] bridge_mode_field;
        logic [1:0] duty_low_bits;
        logic [3:0] unit_mode_select;
    } ccb_ctrl_t;

    // the four bridge outputs
    typedef struct packed {
        logic a;
        logic b;
        logic c;
        logic d;
    } ccb_bridge_t;

endpackage : ccb_pkg

// *** rtl/ccb_deadband.sv ***
// ccb_deadband: delays the rising edge of one raw pwm phase by a count of instruction cycles
// assumes tick_i is a one-cycle instruction-cycle enable
`timescale 1ns/100ps
module ccb_deadband #(
    parameter int W = 7
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         arst_n_i,
    // control
    input  wire logic         tick_i,
    input  wire logic [W-1:0] delay_i,
    input  wire logic         raw_i,
    // delayed phase
    output logic              out_o
);
    logic [W-1:0] cnt;

    // a phase that drops before the count runs out never goes active
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt   <= '0;
            out_o <= 1'b0;
        end else if (!raw_i) begin
            cnt   <= '0;
            out_o <= 1'b0;
        end else if (cnt >= delay_i) begin
            out_o <= 1'b1;
        end else if (tick_i) begin
            cnt <= cnt + 1'b1;
        end
    end
endmodule // ccb_deadband

// *** rtl/ccb_capture_presc.sv ***
// ccb_capture_presc: edge qualification and prescaling of capture events
// assumes pin_i already synchronous to clk_i
`timescale 1ns/100ps
module ccb_capture_presc
    import ccb_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    // control
    input  wire logic [3:0] mode_i,
    input  wire logic       pin_i,
    // qualified event pulse
    output logic            event_o
);
    logic       pin_q;
    logic [3:0] presc;
    logic       cap_mode;
    logic       rise;
    logic       fall;

    assign cap_mode = (mode_i[3:2] == 2'b01);
    assign rise     = pin_i & ~pin_q;
    assign fall     = ~pin_i & pin_q;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= pin_i;
        end
    end

    // prescale counter survives a change between capture settings
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            presc <= '0;
        end else if (!cap_mode) begin
            presc <= '0;
        end else if (rise && (mode_i == MODE_CAP_R4 || mode_i == MODE_CAP_R16)) begin
            if ((mode_i == MODE_CAP_R4 && presc >= PRESC_LAST_4) || presc == PRESC_LAST_16) begin
                presc <= '0;
            end else begin
                presc <= presc + 1'b1;
            end
        end
    end

    always_comb begin
        case (mode_i)
            MODE_CAP_FALL: event_o = fall;
            MODE_CAP_RISE: event_o = rise;
            MODE_CAP_R4:   event_o = rise && presc >= PRESC_LAST_4;
            MODE_CAP_R16:  event_o = rise && presc == PRESC_LAST_16;
            default:       event_o = 1'b0;
        endcase
    end
endmodule // ccb_capture_presc

// *** rtl/ccb_unit.sv ***
// ccb_unit: capture / compare / enhanced bridge pwm unit, top level
// assumes timers are external, all inputs synchronous to clk_i, software pokes the control ports
// Behaviour
// - third timer control picks first or third timer
// - capture copies full 16-bit selected timer count
// - capture on fall, rise, 4th or 16th rise
// - each capture sets sticky event flag
// - newer capture overwrites older value
// - port write on output pin can capture
// - prescaler cleared when off, leaving capture, reset
// - prescale change keeps counter, may interrupt
// - compare match acts on pin, sets flag
// - zero control forces compare latch low
// - mode 1010 only sets flag
// - mode 1011 trigger resets assigned timer
// - trigger starts conversion only if converter enabled
// - bridge field picks single, half, full modes
// - ten-bit base is timer plus quarter phase
// - pwm output waits for new period
// - half bridge drives A and complement B
// - half-bridge dead band delays active edges
// - forward holds A, modulates D
// - reverse holds C, modulates B
// - mode 0000 turns unit off, resets
// - modes 0100-0111 choose capture events
// - modes 1000, 1001, 0010 set, clear, toggle
// - pwm modes set pair polarities
`timescale 1ns/100ps
module ccb_unit
    import ccb_pkg::*;
#(
    parameter int DB_W = 7
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    // software control
    input  wire ccb_pkg::ccb_ctrl_t ctrl_i,
    input  wire logic [DB_W-1:0]  deadband_count_field_i,
    input  wire logic             timer_select_i,       // third_timer_control select: 1 = third timer
    input  wire logic [15:0]      match_value_wr_i,     // match_value_pair write data
    input  wire logic             match_value_we_i,
    input  wire logic             flag_clear_i,
    input  wire logic             adc_enabled_i,
    // pin and port
    input  wire logic             unit_pin_i,
    input  wire logic             pin_direction_bits_i, // 0 = output
    input  wire logic             port_latch_i,
    // timers
    input  wire logic [15:0]      first_timer_count_i,
    input  wire logic [15:0]      third_timer_count_i,
    input  wire logic [7:0]       second_timer_count_i,
    input  wire logic             second_timer_period_match_i,
    // outputs
    output logic [15:0]           match_value_pair_o,
    output logic                  unit_event_flag_o,
    output logic                  compare_latch_o,
    output logic                  first_timer_reset_o,
    output logic                  third_timer_reset_o,
    output logic                  adc_start_o,
    output ccb_pkg::ccb_bridge_t  bridge_o,
    output ccb_pkg::ccb_bridge_t  bridge_oe_o
);
    import ccb_pkg::*;

    typedef enum logic [1:0] {CCB_IDLE, CCB_WAIT, CCB_RUN} ccb_pwm_st_t;

    ccb_pwm_st_t  pwm_st;
    logic [3:0]   mode;
    logic [3:0]   mode_q;
    logic [15:0]  timer_sel;
    logic         pin_eff;
    logic         cap_event;
    logic         cmp_mode;
    logic         pwm_mode;
    logic         cmp_match;
    logic         match_q;
    logic         match_pulse;
    logic [1:0]   qphase;
    logic         qtick;
    logic [9:0]   duty_act;
    logic [9:0]   base10;
    logic         raw_pwm;
    logic         db_a;
    logic         db_b;
    logic         pol_ac;
    logic         pol_bd;
    ccb_bridge_t  next_bridge;
    ccb_bridge_t  next_oe;

    assign mode      = ctrl_i.unit_mode_select;
    assign timer_sel = timer_select_i ? third_timer_count_i : first_timer_count_i;
    // an output pin reflects the port latch, so a port write can look like a pin edge
    assign pin_eff   = pin_direction_bits_i ? unit_pin_i : port_latch_i;
    assign cmp_mode  = (mode == MODE_CMP_TOG) || (mode[3:2] == 2'b10);
    assign pwm_mode  = (mode[3:2] == 2'b11);
    assign cmp_match = cmp_mode && (timer_sel == match_value_pair_o);
    assign match_pulse = cmp_match && !match_q;
    assign qtick     = (qphase == QCLK_LAST);
    assign base10    = {second_timer_count_i, qphase};
    assign raw_pwm   = pwm_st == CCB_RUN && base10 < duty_act;
    assign pol_ac    = mode[1];
    assign pol_bd    = mode[0];

    ccb_capture_presc u_presc (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .mode_i   (mode),
        .pin_i    (pin_eff),
        .event_o  (cap_event)
    );

    ccb_deadband #(.W(DB_W)) u_db_a (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .tick_i   (qtick),
        .delay_i  (deadband_count_field_i),
        .raw_i    (raw_pwm),
        .out_o    (db_a)
    );

    ccb_deadband #(.W(DB_W)) u_db_b (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .tick_i   (qtick),
        .delay_i  (deadband_count_field_i),
        .raw_i    (pwm_st == CCB_RUN && !raw_pwm),
        .out_o    (db_b)
    );

    // quarter-cycle divider, runs free
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            qphase <= '0;
        end else begin
            qphase <= qphase + 2'h1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            match_q <= 1'b0;
            mode_q  <= MODE_OFF;
        end else begin
            match_q <= cmp_match;
            mode_q  <= mode;
        end
    end

    // value register: capture has priority over a software write in the same cycle
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            match_value_pair_o <= '0;
        end else if (cap_event) begin
            match_value_pair_o <= timer_sel;
        end else if (match_value_we_i) begin
            match_value_pair_o <= match_value_wr_i;
        end
    end

    // set wins over clear
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            unit_event_flag_o <= 1'b0;
        end else if (cap_event || match_pulse) begin
            unit_event_flag_o <= 1'b1;
        end else if (flag_clear_i) begin
            unit_event_flag_o <= 1'b0;
        end
    end

    // compare output latch
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            compare_latch_o <= 1'b0;
        end else if (mode == MODE_OFF) begin
            compare_latch_o <= 1'b0;
        end else if (mode != mode_q && mode == MODE_CMP_SET) begin
            compare_latch_o <= 1'b0;
        end else if (mode != mode_q && mode == MODE_CMP_CLR) begin
            compare_latch_o <= 1'b1;
        end else if (match_pulse) begin
            case (mode)
                MODE_CMP_SET: compare_latch_o <= 1'b1;
                MODE_CMP_CLR: compare_latch_o <= 1'b0;
                MODE_CMP_TOG: compare_latch_o <= ~compare_latch_o;
                default:      compare_latch_o <= compare_latch_o;
            endcase
        end
    end

    // special event trigger pulses
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            first_timer_reset_o <= 1'b0;
            third_timer_reset_o <= 1'b0;
            adc_start_o         <= 1'b0;
        end else begin
            first_timer_reset_o <= match_pulse && mode == MODE_CMP_SPEV && !timer_select_i;
            third_timer_reset_o <= match_pulse && mode == MODE_CMP_SPEV && timer_select_i;
            adc_start_o         <= match_pulse && mode == MODE_CMP_SPEV && adc_enabled_i;
        end
    end

    // pwm sequencing: start only on a period boundary
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pwm_st <= CCB_IDLE;
        end else begin
            case (pwm_st)
                CCB_IDLE: if (pwm_mode) pwm_st <= CCB_WAIT;
                CCB_WAIT: if (!pwm_mode) pwm_st <= CCB_IDLE;
                          else if (second_timer_period_match_i) pwm_st <= CCB_RUN;
                CCB_RUN:  if (!pwm_mode) pwm_st <= CCB_IDLE;
                default:  pwm_st <= CCB_IDLE;
            endcase
        end
    end

    // duty only reloads at period start to avoid mid-period glitches
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            duty_act <= '0;
        end else if (second_timer_period_match_i) begin
            duty_act <= {match_value_pair_o[7:0], ctrl_i.duty_low_bits};
        end
    end

    always_comb begin
        next_bridge = '0;
        next_oe     = '0;
        if (pwm_mode) begin
            case (ctrl_i.bridge_mode_field)
                BRIDGE_SINGLE: begin
                    next_bridge.a = raw_pwm;
                    next_oe.a     = 1'b1;
                end
                BRIDGE_HALF: begin
                    next_bridge.a = db_a;
                    next_bridge.b = db_b;
                    next_oe.a     = 1'b1;
                    next_oe.b     = 1'b1;
                end
                BRIDGE_FWD: begin
                    next_bridge.a = pwm_st == CCB_RUN;
                    next_bridge.d = raw_pwm;
                    next_oe       = '1;
                end
                BRIDGE_REV: begin
                    next_bridge.c = pwm_st == CCB_RUN;
                    next_bridge.b = raw_pwm;
                    next_oe       = '1;
                end
                default: next_bridge = '0;
            endcase
            next_bridge.a = next_bridge.a ^ pol_ac;
            next_bridge.c = next_bridge.c ^ pol_ac;
            next_bridge.b = next_bridge.b ^ pol_bd;
            next_bridge.d = next_bridge.d ^ pol_bd;
        end else if (cmp_mode && mode != MODE_CMP_SWI) begin
            next_bridge.a = compare_latch_o;
            next_oe.a     = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bridge_o    <= '0;
            bridge_oe_o <= '0;
        end else begin
            bridge_o    <= next_bridge;
            bridge_oe_o <= next_oe;
        end
    end

    // assertions
    flag_sticky_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        unit_event_flag_o && !flag_clear_i |=> unit_event_flag_o)
        else $error("event flag dropped without clear");
    capture_copy_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        cap_event |=> match_value_pair_o == $past(timer_sel))
        else $error("capture value wrong");
    capture_flag_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        cap_event |=> unit_event_flag_o)
        else $error("capture did not set flag");
    zero_ctrl_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ctrl_i == CTRL_RESET |=> !compare_latch_o)
        else $error("compare latch not cleared");
    swi_pin_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        mode == MODE_CMP_SWI && $stable(mode) |=> $stable(compare_latch_o))
        else $error("software interrupt mode moved latch");
    spev_reset_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        match_pulse && mode == MODE_CMP_SPEV && timer_select_i |=> third_timer_reset_o)
        else $error("special event missed timer reset");
    adc_gate_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        adc_start_o |-> $past(adc_enabled_i))
        else $error("conversion started while disabled");
    pwm_wait_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        pwm_st == CCB_WAIT && !second_timer_period_match_i |=> pwm_st != CCB_RUN)
        else $error("pwm started mid period");
    toggle_cmp_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        match_pulse && mode == MODE_CMP_TOG && $stable(mode) && ctrl_i != CTRL_RESET
        |=> compare_latch_o != $past(compare_latch_o))
        else $error("toggle compare did not toggle");
endmodule // ccb_unit

// *** sim/ccb_timer_model.sv ***
// ccb_timer_model: the external timers that feed the unit
// assumes the unit clock drives every count; timer resets come from the unit
`timescale 1ns/100ps
module ccb_timer_model #(
    parameter int PERIOD = 9
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    // software side
    input  wire logic        run_i,
    input  wire logic        load_i,
    input  wire logic [15:0] load_val_i,
    // resets from the unit
    input  wire logic        rst1_i,
    input  wire logic        rst3_i,
    // counts
    output logic      [15:0] t1_o,
    output logic      [15:0] t3_o,
    output logic      [7:0]  t2_o,
    output logic             pm_o
);
    logic [1:0] pre;

    // counts move on the unit clock only; asynchronous counting is not offered
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            t1_o <= 16'h0;
            t3_o <= 16'h0;
        end else if (load_i) begin
            t1_o <= load_val_i;
            t3_o <= ~load_val_i;
        end else begin
            t1_o <= rst1_i ? 16'h0 : t1_o + 16'(run_i);
            t3_o <= rst3_i ? 16'h0 : t3_o + 16'(run_i);
        end
    end

    // second timer steps once per instruction cycle and wraps at its period
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pre  <= 2'h0;
            t2_o <= 8'h0;
            pm_o <= 1'b0;
        end else begin
            pre  <= pre + 2'h1;
            pm_o <= (pre == 2'h3) && (t2_o == 8'(PERIOD));
            if (pre == 2'h3) begin
                t2_o <= (t2_o == 8'(PERIOD)) ? 8'h0 : t2_o + 8'h1;
            end
        end
    end
endmodule // ccb_timer_model

// *** sim/tb_ccb_unit.sv ***
// tb_ccb_unit: directed sequences over capture, compare and bridge pwm
// assumes the timer model as far side; inputs change on the falling clock edge
`timescale 1ns/100ps
module tb_ccb_unit;
    import ccb_pkg::*;
    logic clk_i, arst_n_i, tsel, mwe, fclr, adc, pin, dir, plat, run, ld, pm;
    logic flag, cl, r1, r3, adcs;
    logic [15:0] mv, ldv, t1, t3, val;
    logic [7:0] t2;
    logic [6:0] db;
    ccb_ctrl_t ctrl;
    ccb_bridge_t br, oe;
    int failures, checked, cycles, n[4];

    ccb_timer_model #(.PERIOD(9)) far (.clk_i(clk_i), .arst_n_i(arst_n_i), .run_i(run), .load_i(ld),
        .load_val_i(ldv), .rst1_i(r1), .rst3_i(r3), .t1_o(t1), .t3_o(t3), .t2_o(t2), .pm_o(pm));

    ccb_unit dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .ctrl_i(ctrl), .deadband_count_field_i(db),
        .timer_select_i(tsel), .match_value_wr_i(mv), .match_value_we_i(mwe), .flag_clear_i(fclr),
        .adc_enabled_i(adc), .unit_pin_i(pin), .pin_direction_bits_i(dir), .port_latch_i(plat),
        .first_timer_count_i(t1), .third_timer_count_i(t3), .second_timer_count_i(t2),
        .second_timer_period_match_i(pm), .match_value_pair_o(val), .unit_event_flag_o(flag),
        .compare_latch_o(cl), .first_timer_reset_o(r1), .third_timer_reset_o(r3),
        .adc_start_o(adcs), .bridge_o(br), .bridge_oe_o(oe));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // a hang is cut short well past the expected run of under 1500 cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 8000) begin
            failures++;
            close_out();
        end
    end

    // wide enough for four packed 16-bit counts, so no packed compare is cut short
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge clk_i);
    endtask

    task automatic setm(input logic [3:0] m, input logic [1:0] b);
        ctrl.unit_mode_select = m;
        ctrl.bridge_mode_field = b;
        cyc(2);
    endtask

    // a flag clear after each change into a capture mode or a set, clear, toggle or interrupt compare mode, since the change may capture falsely
    task automatic clr();
        fclr = 1'b1;
        cyc(1);
        fclr = 1'b0;
        cyc(1);
    endtask

    task automatic edges(input int k);
        repeat (k) begin
            pin = 1'b1;
            cyc(2);
            pin = 1'b0;
            cyc(2);
        end
    endtask

    task automatic load(input logic [15:0] v);
        ld = 1'b1;
        ldv = v;
        cyc(1);
        ld = 1'b0;
    endtask

    task automatic wflag();
        run = 1'b1;
        for (int i = 0; i < 20 && flag !== 1'b1; i++) cyc(1);
        run = 1'b0;
    endtask

    // a whole pwm period of samples, so the count is the same at any phase
    task automatic measure();
        n = '{0, 0, 0, 0};
        for (int i = 0; i < 50 && pm !== 1'b1; i++) cyc(1);
        cyc(2);
        repeat (40) begin
            n[0] += int'(br.a);
            n[1] += int'(br.b);
            n[2] += int'(br.c);
            n[3] += int'(br.d);
            cyc(1);
        end
    endtask

    initial begin
        {arst_n_i, tsel, mwe, fclr, adc, pin, plat, run, ld} = '0;
        {mv, ldv, db} = '0;
        dir = 1'b1;
        ctrl = '{bridge_mode_field: 2'h0, duty_low_bits: 2'h2, unit_mode_select: MODE_OFF};
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        arst_n_i = 1'b1;
        cyc(1);
        check(flag, 1'b0);
        check(oe, 4'h0);
        for (int i = 0; i < 2; i++) begin
            setm(i ? MODE_CAP_RISE : MODE_CAP_FALL, 2'h0);
            clr();
            load(16'h1230 + 16'(i));
            pin = 1'b1;
            cyc(2);
            check(flag, 16'(i));
            pin = 1'b0;
            cyc(2);
            check(flag, 1'b1);
            check(val, 16'h1230 + 16'(i));
        end
        load(16'h4321);
        edges(1);
        check(val, 16'h4321);
        check(flag, 1'b1);
        tsel = 1'b1;
        load(16'h0f0f);
        edges(1);
        check(val, 16'hf0f0);
        tsel = 1'b0;
        clr();
        check(flag, 1'b0);
        dir = 1'b0;
        plat = 1'b1;
        cyc(2);
        check(flag, 1'b1);
        plat = 1'b0;
        dir = 1'b1;
        setm(MODE_CAP_R4, 2'h0);
        clr();
        edges(3);
        check(flag, 1'b0);
        edges(1);
        check(flag, 1'b1);
        setm(MODE_OFF, 2'h0);
        setm(MODE_CAP_R16, 2'h0);
        clr();
        edges(15);
        check(flag, 1'b0);
        edges(1);
        check(flag, 1'b1);
        setm(MODE_CAP_R4, 2'h0);
        clr();
        edges(2);
        setm(MODE_OFF, 2'h0);
        setm(MODE_CAP_R4, 2'h0);
        clr();
        edges(3);
        check(flag, 1'b0);
        edges(1);
        check(flag, 1'b1);
        edges(2);
        setm(MODE_CAP_R16, 2'h0);
        clr();
        edges(13);
        check(flag, 1'b0);
        edges(1);
        check(flag, 1'b1);
        setm(MODE_OFF, 2'h0);
        mv = 16'h0028;
        mwe = 1'b1;
        cyc(1);
        mwe = 1'b0;
        cyc(1);
        check(val, 16'h0028);
        setm(MODE_CMP_CLR, 2'h0);
        clr();
        check(cl, 1'b1);
        load(16'h0022);
        wflag();
        check(flag, 1'b1);
        check(cl, 1'b0);
        setm(MODE_CMP_SET, 2'h0);
        clr();
        check(cl, 1'b0);
        load(16'h0022);
        wflag();
        check(cl, 1'b1);
        setm(MODE_OFF, 2'h0);
        check(cl, 1'b0);
        setm(MODE_CMP_TOG, 2'h0);
        clr();
        load(16'h0022);
        wflag();
        check(cl, 1'b1);
        setm(MODE_OFF, 2'h0);
        setm(MODE_CMP_SWI, 2'h0);
        clr();
        load(16'h0022);
        wflag();
        check(flag, 1'b1);
        check(cl, 1'b0);
        setm(MODE_CMP_SPEV, 2'h0);
        adc = 1'b1;
        load(16'h0020);
        run = 1'b1;
        for (int i = 0; i < 20 && r1 !== 1'b1; i++) cyc(1);
        check({r1, r3, adcs}, 3'b101);
        adc = 1'b0;
        tsel = 1'b1;
        load(~16'h0024);
        for (int i = 0; i < 20 && r3 !== 1'b1; i++) cyc(1);
        check({r1, r3, adcs}, 3'b010);
        run = 1'b0;
        tsel = 1'b0;
        setm(MODE_OFF, 2'h0);
        mv = 16'h0005;
        mwe = 1'b1;
        cyc(1);
        mwe = 1'b0;
        for (int i = 0; i < 50 && pm !== 1'b1; i++) cyc(1);
        cyc(2);
        ctrl = '{bridge_mode_field: BRIDGE_FWD, duty_low_bits: 2'h2, unit_mode_select: 4'hc};
        cyc(3);
        check(br.a, 1'b0);
        measure();
        check(oe, 4'hf);
        check({16'(n[0]), 16'(n[1]), 16'(n[2])}, {16'd40, 16'd0, 16'd0});
        check(16'(n[3]), 16'd22);
        setm(4'hc, BRIDGE_REV);
        measure();
        measure();
        check({16'(n[0]), 16'(n[1]), 16'(n[2]), 16'(n[3])}, {16'd0, 16'd22, 16'd40, 16'd0});
        setm(4'hf, BRIDGE_FWD);
        measure();
        measure();
        check({16'(n[0]), 16'(n[1]), 16'(n[2]), 16'(n[3])}, {16'd0, 16'd40, 16'd40, 16'd18});
        setm(4'hd, BRIDGE_FWD);
        measure();
        check({16'(n[0]), 16'(n[1]), 16'(n[2]), 16'(n[3])}, {16'd40, 16'd40, 16'd0, 16'd18});
        setm(4'hc, BRIDGE_SINGLE);
        measure();
        check(oe, 4'h8);
        check({16'(n[0]), 16'(n[1]), 16'(n[2]), 16'(n[3])}, {16'd22, 16'd0, 16'd0, 16'd0});
        setm(4'hc, BRIDGE_HALF);
        measure();
        check(oe, 4'hc);
        check({16'(n[0]), 16'(n[1])}, {16'd22, 16'd18});
        db = 7'h02;
        measure();
        check(n[0] >= 14 && n[0] <= 17 && n[1] >= 10 && n[1] <= 13, 1'b1);
        db = 7'h07;
        measure();
        check(16'(n[0]), 16'd0);
        close_out();
    end
endmodule // tb_ccb_unit
